// file: logic/sdr_defines.svh
// constants of the stepper driver serial register bank (registers 3..7)
// assumes: included by bare name, 25 MHz core clock
// Notes on behaviour
// [R01] entries 2,3 in reg3, entry 8 in reg6
// [R02] reg3 bit5 low routes pwm, high floats pin
// [R03] threshold spread over reg3, reg4, reg5
// [R04] reg4/5 hold entries 4..7, read/write
// [R05] reg6 bits 6,5 open load B, A
// [R06] reg6 bit7 flags reference current error
// [R07] quadrant rise sum below threshold sets stall
// [R08] reg6 bit9 picks 20 or 30 kHz
// [R09] reg6 bit10 picks 1.5 or 2.5 us filter
// [R10] reg6 bit11 mirrors stall flag on pin
// [R11] reg6 bit12 write clears reg6 status bits
// [R12] reg7 bits 7:0 transistor overcurrent flags
// [R13] reg7 bits 9:8 supply under/over state
// [R14] reg7 bits 11:10 warning, latched thermal shutdown
// [R15] reg7 bit12 write clears all reg7
// [R16] fault is OR of status bits except the reg6 stall flag
// [R17] serial out shows fault early in frame
// [R18] only exactly sixteen clocks allow a write
// [R19] chip select rise copies word to register
// [R20] controller may repeat command to verify
// [R21] no daisy chain, one select per device
// [R22] first three bits address the register
// [R23] sample rising edge, shift on falling
// [R24] addressed register shifts out same frame
// [R25] serial out driven only while selected
// [R26] status bits stay set until cleared
// [R27] rise sum counted in oscillator ticks
`ifndef SDR_DEFINES_SVH
`define SDR_DEFINES_SVH
// ----------------------------------------
// map and fields
// ----------------------------------------
`define SDR_ADDR_REG3      3'h3
`define SDR_ADDR_REG7      3'h7
`define SDR_REG_RESET      13'h0000
`define SDR_PROF_LO        0
`define SDR_PROF_HI        8
`define SDR_R3_PWM_DISABLE 5
`define SDR_R3_THR_LSB     6
`define SDR_THR_LSB        5
`define SDR_R6_OPEN_A      5
`define SDR_R6_OPEN_B      6
`define SDR_R6_REF_ERR     7
`define SDR_R6_STALL       8
`define SDR_R6_FREQ        9
`define SDR_R6_FILTER      10
`define SDR_R6_MIRROR      11
`define SDR_REG_CLEAR      12
`define SDR_R7_UNDER       8
`define SDR_R7_OVER        9
`define SDR_R7_TWARN       10
`define SDR_R7_TSD         11
`define SDR_FRAME_BITS     5'h10
`define SDR_CNT_SAT        5'h11
// ----------------------------------------
// timing
// ----------------------------------------
`define SDR_CLK_HZ         25000000
`define SDR_CLK_PERIOD_NS  40
`define SDR_OSC_HZ         2000000
`define SDR_TICK_CYCLES    (`SDR_CLK_HZ / `SDR_OSC_HZ)
`define SDR_PWM_FAST_HZ    30000
`define SDR_PWM_SLOW_HZ    20000
`define SDR_PWM_FAST_CYC   (`SDR_CLK_HZ / `SDR_PWM_FAST_HZ)
`define SDR_PWM_SLOW_CYC   (`SDR_CLK_HZ / `SDR_PWM_SLOW_HZ)
`define SDR_FILT_SHORT_NS  1500
`define SDR_FILT_LONG_NS   2500
`define SDR_FILT_SHORT_CYC ((`SDR_FILT_SHORT_NS + `SDR_CLK_PERIOD_NS - 1) / `SDR_CLK_PERIOD_NS)
`define SDR_FILT_LONG_CYC  ((`SDR_FILT_LONG_NS + `SDR_CLK_PERIOD_NS - 1) / `SDR_CLK_PERIOD_NS)
`endif

// file: logic/sdr_pkg.sv
// types of the stepper driver serial register bank
// assumes: compiled before the design modules
package sdr_pkg;
    typedef enum logic [1:0] {
        SDR_IDLE   = 2'b00,
        SDR_FRAME  = 2'b01,
        SDR_COMMIT = 2'b10,
        SDR_CLEAR  = 2'b11
    } sdr_state_t;

    typedef logic [4:0][12:0] sdr_bank_t;

    typedef struct packed {
        sdr_state_t  state;
        logic [1:0]  csSync;
        logic [14:0] evSync1;
        logic [14:0] evSync2;
        sdr_bank_t   regs;
        sdr_bank_t   snap;
        logic        snapFault;
        logic [3:0]  tickCnt;
        logic [7:0]  riseSum;
        logic        linkClear;
        logic        serialOutOe;
        logic        pwmPin;
        logic        pwmPinOe;
        logic [10:0] pwmPeriodCycles;
        logic [6:0]  glitchFilterCycles;
    } sdr_core_t;

    typedef struct packed {
        logic [4:0]  cnt;
        logic [15:0] rxWord;
        logic [11:0] txShift;
        logic        txBit;
    } sdr_link_t;
endpackage : sdr_pkg

// file: logic/sdr_spi_link.sv
// serial-clock side of the register bank: shift in, edge count, shift out
// assumes: linkClear only changes while the serial clock is idle
`include "sdr_defines.svh"

module sdr_spi_link (
    // link clock and clear from the core
    input  wire logic              serialClk,
    input  wire logic              linkClear,
    // serial data
    input  wire logic              serialIn,
    output logic                   serialOut,
    // frozen register image from the core
    input  wire sdr_pkg::sdr_bank_t snapWords,
    input  wire logic              snapFault,
    // frame result for the core
    output logic [4:0]             edgeCount,
    output logic [15:0]            rxWord
);
    sdr_pkg::sdr_link_t l;
    sdr_pkg::sdr_link_t next_l;
    logic [2:0]         addr;
    logic [12:0]        word;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_l = l;
        addr   = {serialIn, l.rxWord[15], l.rxWord[14]};
        word   = (addr >= `SDR_ADDR_REG3) ? snapWords[addr - `SDR_ADDR_REG3] : `SDR_REG_RESET;
        // counts past sixteen so that long frames stay distinguishable
        if (l.cnt != `SDR_CNT_SAT) begin
            next_l.cnt = l.cnt + 5'h01; // [R18]
        end
        next_l.rxWord = {serialIn, l.rxWord[15:1]}; // [R23]
        if (l.cnt == 5'h02) begin
            next_l.txBit   = word[0]; // [R24]
            next_l.txShift = word[12:1];
        end else if (l.cnt > 5'h02 && l.cnt < 5'h0F) begin
            next_l.txBit   = l.txShift[0];
            next_l.txShift = {1'b0, l.txShift[11:1]};
        end else begin
            next_l.txBit = snapFault; // [R17]
        end
    end

    // clear is released only while the link clock stands still
    always_ff @(posedge serialClk or posedge linkClear) begin
        if (linkClear) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // output changes on the falling edge
    always_ff @(negedge serialClk or posedge linkClear) begin
        if (linkClear) begin
            serialOut <= 1'b0;
        end else begin
            serialOut <= l.txBit; // [R23]
        end
    end

    assign edgeCount = l.cnt;
    assign rxWord    = l.rxWord;
endmodule // sdr_spi_link

// file: logic/sdr_reg_bank.sv
// register bank 3..7 of a bipolar stepper driver behind a 16-bit serial port
// assumes: pwmBridgeA and quadrantEnd come from core_clk logic;
// status inputs, select and serial pins are asynchronous
`include "sdr_defines.svh"

module sdr_reg_bank (
    // core clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // serial port
    input  wire logic        serialClk,
    input  wire logic        selectLow,
    input  wire logic        serialIn,
    output logic             serialOut,
    output logic             serialOutOe,
    // pwm controller and stall measurement
    input  wire logic        pwmBridgeA,
    input  wire logic        quadrantEnd,
    output logic             pwmPin,
    output logic             pwmPinOe,
    // analog status events
    input  wire logic [7:0]  overcurrent,
    input  wire logic        openLoadA,
    input  wire logic        openLoadB,
    input  wire logic        referenceCurrentBad,
    input  wire logic        supplyUnder,
    input  wire logic        supplyOver,
    input  wire logic        thermalWarning,
    input  wire logic        thermalShutdown,
    // current profile entries
    output logic [4:0]       profileEntry2,
    output logic [4:0]       profileEntry3,
    output logic [4:0]       profileEntry4,
    output logic [4:0]       profileEntry5,
    output logic [4:0]       profileEntry6,
    output logic [4:0]       profileEntry7,
    output logic [4:0]       profileEntry8,
    // derived controls
    output logic [7:0]       stallThreshold,
    output logic [10:0]      pwmPeriodCycles,
    output logic [6:0]       glitchFilterCycles,
    output logic             bridgeDisable
);
    sdr_pkg::sdr_core_t r;
    sdr_pkg::sdr_core_t next_r;

    logic [4:0]  edgeCount;
    logic [15:0] rxWord;

    // ----------------------------------------
    // decoding helpers
    // ----------------------------------------
    function automatic logic isMapped(input logic [2:0] addr);
        isMapped = (addr >= `SDR_ADDR_REG3) && (addr <= `SDR_ADDR_REG7); // [R22]
    endfunction

    function automatic logic [2:0] bankIndex(input logic [2:0] addr);
        bankIndex = addr - `SDR_ADDR_REG3;
    endfunction

    // ----------------------------------------
    // link side
    // ----------------------------------------
    sdr_spi_link u_link (
        .serialClk (serialClk),
        .linkClear (r.linkClear),
        .serialIn  (serialIn),
        .serialOut (serialOut),
        .snapWords (r.snap),
        .snapFault (r.snapFault),
        .edgeCount (edgeCount),
        .rxWord    (rxWord)
    );

    // ----------------------------------------
    // core next state
    // ----------------------------------------
    logic        selected;
    logic [7:0]  threshold;
    logic        fault;
    logic        stallEvent;
    logic [12:0] wdata;
    logic [2:0]  waddr;
    logic        writeOk;
    logic        clear6;
    logic        clear7;
    logic [14:0] ev;

    always_comb begin
        next_r     = r;
        selected   = ~r.csSync[1];
        waddr      = rxWord[2:0];
        wdata      = rxWord[15:3];
        writeOk    = 1'b0;
        clear6     = 1'b0;
        clear7     = 1'b0;
        stallEvent = 1'b0;
        ev         = r.evSync2;

        // ---------------- synchronisers
        next_r.csSync  = {r.csSync[0], selectLow};
        next_r.evSync1 = {thermalShutdown, thermalWarning, supplyOver, supplyUnder,
                          referenceCurrentBad, openLoadB, openLoadA, overcurrent};
        next_r.evSync2 = r.evSync1;

        // ---------------- stall threshold and fault
        threshold = {r.regs[2][`SDR_THR_LSB +: 3],
                     r.regs[1][`SDR_THR_LSB +: 3],
                     r.regs[0][`SDR_R3_THR_LSB +: 2]}; // [R03]
        fault = (|r.regs[3][`SDR_R6_REF_ERR:`SDR_R6_OPEN_A])
              | (|r.regs[4][`SDR_R7_TSD:0]); // [R16]

        // ---------------- frame sequencing
        next_r.linkClear = 1'b0;
        case (r.state)
            sdr_pkg::SDR_IDLE: begin
                // image refreshes only between frames so shifted words stay stable
                next_r.snap      = r.regs; // [R24]
                next_r.snapFault = fault;
                if (selected) begin
                    next_r.state = sdr_pkg::SDR_FRAME;
                end
            end
            sdr_pkg::SDR_FRAME: begin
                if (!selected) begin
                    next_r.state = sdr_pkg::SDR_COMMIT;
                end
            end
            sdr_pkg::SDR_COMMIT: begin
                // link counters are quiet now: the clock idles while deselected
                writeOk          = (edgeCount == `SDR_FRAME_BITS) && isMapped(waddr); // [R18]
                next_r.linkClear = 1'b1;
                next_r.state     = sdr_pkg::SDR_CLEAR;
            end
            sdr_pkg::SDR_CLEAR: begin
                next_r.state = sdr_pkg::SDR_IDLE;
            end
            default: begin
                next_r.state = sdr_pkg::SDR_IDLE;
            end
        endcase

        // ---------------- register writes
        if (writeOk) begin // [R19]
            case (bankIndex(waddr))
                3'h0, 3'h1, 3'h2: begin
                    next_r.regs[bankIndex(waddr)] = wdata; // [R01] [R04]
                end
                3'h3: begin
                    next_r.regs[3][4:0] = wdata[4:0]; // [R01]
                    next_r.regs[3][`SDR_R6_MIRROR:`SDR_R6_FREQ] =
                        wdata[`SDR_R6_MIRROR:`SDR_R6_FREQ];
                    clear6 = wdata[`SDR_REG_CLEAR];
                end
                3'h4: begin
                    clear7 = wdata[`SDR_REG_CLEAR];
                end
                default: begin
                    next_r.regs = r.regs;
                end
            endcase
        end
        if (clear6) begin
            next_r.regs[3][`SDR_R6_STALL:`SDR_R6_OPEN_A] = 4'h0; // [R11]
        end
        if (clear7) begin
            next_r.regs[4][`SDR_R7_TSD:0] = 12'h000; // [R15]
        end

        // ---------------- rise time sum in oscillator ticks
        if (r.tickCnt == 4'(`SDR_TICK_CYCLES - 1)) begin
            next_r.tickCnt = 4'h0;
        end else begin
            next_r.tickCnt = r.tickCnt + 4'h1;
        end
        if (quadrantEnd) begin
            stallEvent     = r.riseSum < threshold; // [R07]
            next_r.riseSum = 8'h00; // [R27]
        end else if (pwmBridgeA && r.tickCnt == 4'h0 && r.riseSum != 8'hFF) begin
            next_r.riseSum = r.riseSum + 8'h01; // [R27]
        end

        // ---------------- sticky status, a set beats a same-cycle clear
        next_r.regs[3][`SDR_R6_OPEN_A]  = next_r.regs[3][`SDR_R6_OPEN_A]  | ev[8];  // [R05] [R26]
        next_r.regs[3][`SDR_R6_OPEN_B]  = next_r.regs[3][`SDR_R6_OPEN_B]  | ev[9];  // [R05]
        next_r.regs[3][`SDR_R6_REF_ERR] = next_r.regs[3][`SDR_R6_REF_ERR] | ev[10]; // [R06]
        next_r.regs[3][`SDR_R6_STALL]   = next_r.regs[3][`SDR_R6_STALL]   | stallEvent; // [R07]
        next_r.regs[4][7:0]             = next_r.regs[4][7:0] | ev[7:0]; // [R12] [R26]
        next_r.regs[4][`SDR_R7_UNDER]   = next_r.regs[4][`SDR_R7_UNDER] | ev[11]; // [R13]
        next_r.regs[4][`SDR_R7_OVER]    = next_r.regs[4][`SDR_R7_OVER]  | ev[12]; // [R13]
        next_r.regs[4][`SDR_R7_TWARN]   = next_r.regs[4][`SDR_R7_TWARN] | ev[13]; // [R14]
        next_r.regs[4][`SDR_R7_TSD]     = next_r.regs[4][`SDR_R7_TSD]   | ev[14]; // [R14]
        next_r.regs[3][`SDR_REG_CLEAR]  = 1'b0;
        next_r.regs[4][`SDR_REG_CLEAR]  = 1'b0;

        // ---------------- pins and derived controls
        next_r.serialOutOe = selected; // [R25]
        next_r.pwmPinOe    = ~r.regs[0][`SDR_R3_PWM_DISABLE]; // [R02]
        next_r.pwmPin      = r.regs[3][`SDR_R6_MIRROR] ? r.regs[3][`SDR_R6_STALL]
                                                       : pwmBridgeA; // [R10]
        next_r.pwmPeriodCycles = r.regs[3][`SDR_R6_FREQ] ? 11'(`SDR_PWM_SLOW_CYC)
                                                         : 11'(`SDR_PWM_FAST_CYC); // [R08]
        next_r.glitchFilterCycles = r.regs[3][`SDR_R6_FILTER] ? 7'(`SDR_FILT_LONG_CYC)
                                                              : 7'(`SDR_FILT_SHORT_CYC); // [R09]
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            r                    <= '0;
            r.csSync             <= 2'b11;
            r.linkClear          <= 1'b1;
            r.pwmPeriodCycles    <= 11'(`SDR_PWM_FAST_CYC);
            r.glitchFilterCycles <= 7'(`SDR_FILT_SHORT_CYC);
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // outputs, all straight from state flops
    // ----------------------------------------
    assign serialOutOe        = r.serialOutOe;
    assign pwmPin             = r.pwmPin;
    assign pwmPinOe           = r.pwmPinOe;
    assign profileEntry2      = r.regs[0][`SDR_PROF_LO +: 5]; // [R01]
    assign profileEntry3      = r.regs[0][`SDR_PROF_HI +: 5];
    assign profileEntry4      = r.regs[1][`SDR_PROF_LO +: 5]; // [R04]
    assign profileEntry5      = r.regs[1][`SDR_PROF_HI +: 5];
    assign profileEntry6      = r.regs[2][`SDR_PROF_LO +: 5];
    assign profileEntry7      = r.regs[2][`SDR_PROF_HI +: 5];
    assign profileEntry8      = r.regs[3][`SDR_PROF_LO +: 5];
    assign stallThreshold     = threshold;
    assign pwmPeriodCycles    = r.pwmPeriodCycles;
    assign glitchFilterCycles = r.glitchFilterCycles;
    assign bridgeDisable      = r.regs[4][`SDR_R7_TSD]; // [R14]
endmodule // sdr_reg_bank

// file: dv/sdr_reg_bank_monitor.sv
// port checker for the stepper driver register bank
// assumes: bound to sdr_reg_bank, all checks in the core clock domain
module sdr_reg_bank_monitor (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        srst,
    // serial port and status
    input wire logic        selectLow,
    input wire logic        serialOut,
    input wire logic        serialOutOe,
    input wire logic        thermalShutdown,
    input wire logic        bridgeDisable,
    // configuration outputs
    input wire logic [4:0]  profileEntry2,
    input wire logic [4:0]  profileEntry8,
    input wire logic [7:0]  stallThreshold,
    input wire logic [10:0] pwmPeriodCycles,
    input wire logic [6:0]  glitchFilterCycles
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    out_off_a: assert property (selectLow [*4] |-> !serialOutOe)
        else $error("serial out driven while deselected");
    out_on_a: assert property (!selectLow [*4] |-> serialOutOe)
        else $error("serial out not driven while selected");
    // the commit clear may zero the output a few cycles after select rises
    out_hold_a: assert property (selectLow [*8] |-> $stable(serialOut))
        else $error("serial out moved outside a frame");
    period_map_a: assert property (pwmPeriodCycles == 11'h341 || pwmPeriodCycles == 11'h4E2)
        else $error("pwm period off both settings");
    filter_map_a: assert property (glitchFilterCycles == 7'h26 || glitchFilterCycles == 7'h3F)
        else $error("glitch filter off both settings");
    tsd_set_a: assert property ($rose(thermalShutdown) |-> ##[1:5] bridgeDisable)
        else $error("shutdown did not disable bridges");
    tsd_keep_a: assert property ($fell(bridgeDisable) |-> !$past(selectLow, 8))
        else $error("shutdown released without a frame");
    cfg_commit_a: assert property (!$stable({profileEntry2, profileEntry8, stallThreshold,
        pwmPeriodCycles, glitchFilterCycles}) |-> !$past(selectLow, 8))
        else $error("configuration changed without a frame");
endmodule // sdr_reg_bank_monitor

bind sdr_reg_bank sdr_reg_bank_monitor mon (.core_clk(core_clk), .srst(srst), .selectLow(selectLow),
    .serialOut(serialOut), .serialOutOe(serialOutOe), .thermalShutdown(thermalShutdown),
    .bridgeDisable(bridgeDisable), .profileEntry2(profileEntry2), .profileEntry8(profileEntry8),
    .stallThreshold(stallThreshold), .pwmPeriodCycles(pwmPeriodCycles),
    .glitchFilterCycles(glitchFilterCycles));

// file: dv/sdr_spi_master.sv
// serial controller model: mode 0, lsb first, own select line
// assumes: sole device on its select, serial clock runs only in frames
module sdr_spi_master (
    // serial port
    output logic      serialClk,
    output logic      selectLow,
    output logic      serialIn,
    input  wire logic serialOut
);
    timeunit 1ns;
    timeprecision 100ps;

    // released lines sit at their pull levels: select high, clock and data low
    initial begin
        serialClk = 1'b0;
        selectLow = 1'b1;
        serialIn  = 1'b0;
    end

    task automatic xfer(input logic [15:0] word, input int edges, output logic [15:0] rx);
        rx = 16'h0000;
        selectLow = 1'b0;
        #200;
        for (int i = 0; i < edges; i++) begin
            serialIn = word[i % 16];
            #7.5 serialClk = 1'b1;
            if (i < 16) rx[i] = serialOut;
            #7.5 serialClk = 1'b0;
        end
        serialIn = 1'b0;
        // select never moves on a core rising edge, where it would race the synchroniser
        #105 selectLow = 1'b1;
        // long gap so the commit has landed; frames stay a whole number of core periods apart
        #(3455 - 15 * edges);
    endtask
endmodule // sdr_spi_master

// file: dv/sdr_reg_bank_test.sv
// self-checking bench of the stepper driver register bank
// assumes: sdr_spi_master plays the controller on the serial port
module sdr_reg_bank_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic        serialClk, selectLow, serialIn, serialOut, serialOutOe, pwmPin, pwmPinOe, bridgeDisable;
    logic        pwmBridgeA = 1'b0, quadrantEnd = 1'b0;
    logic [7:0]  overcurrent = 8'h00, stallThreshold;
    logic [6:0]  lvls = 7'h00;
    wire         thermalShutdown, thermalWarning, supplyOver, supplyUnder, refBad, openLoadB, openLoadA;
    logic [4:0]  profileEntry2, profileEntry3, profileEntry4, profileEntry5, profileEntry6;
    logic [4:0]  profileEntry7, profileEntry8;
    logic [10:0] pwmPeriodCycles;
    logic [6:0]  glitchFilterCycles;
    logic [15:0] rx;
    int          bad_count = 0, check_count = 0, cycles = 0;

    assign {thermalShutdown, thermalWarning, supplyOver, supplyUnder, refBad, openLoadB, openLoadA} = lvls;
    always #20 core_clk = ~core_clk;

    // an undriven data line shows the inverse of the last value, so a late enable is caught
    sdr_spi_master master (.serialClk(serialClk), .selectLow(selectLow), .serialIn(serialIn),
        .serialOut(serialOutOe ? serialOut : ~serialOut));
    sdr_reg_bank uut (.core_clk(core_clk), .srst(srst), .serialClk(serialClk), .selectLow(selectLow),
        .serialIn(serialIn), .serialOut(serialOut), .serialOutOe(serialOutOe), .pwmBridgeA(pwmBridgeA),
        .quadrantEnd(quadrantEnd), .pwmPin(pwmPin), .pwmPinOe(pwmPinOe), .overcurrent(overcurrent),
        .openLoadA(openLoadA), .openLoadB(openLoadB), .referenceCurrentBad(refBad),
        .supplyUnder(supplyUnder), .supplyOver(supplyOver), .thermalWarning(thermalWarning),
        .thermalShutdown(thermalShutdown), .profileEntry2(profileEntry2), .profileEntry3(profileEntry3),
        .profileEntry4(profileEntry4), .profileEntry5(profileEntry5), .profileEntry6(profileEntry6),
        .profileEntry7(profileEntry7), .profileEntry8(profileEntry8), .stallThreshold(stallThreshold),
        .pwmPeriodCycles(pwmPeriodCycles), .glitchFilterCycles(glitchFilterCycles),
        .bridgeDisable(bridgeDisable));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            bad_count++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [12:0] d);
        master.xfer({d, a}, 16, rx);
    endtask

    // seventeen clocks: the frame is refused, so reading never disturbs the register
    task automatic rd(input logic [2:0] a, output logic [12:0] d);
        master.xfer({13'h0000, a}, 17, rx);
        d = rx[15:3];
    endtask

    task automatic quadrant();
        @(negedge core_clk);
        quadrantEnd = 1'b1;
        @(negedge core_clk);
        quadrantEnd = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [12:0] d;
        check(serialOutOe, 1'b0);
        check(pwmPinOe, 1'b1);
        check(pwmPeriodCycles, 11'h341);
        check(glitchFilterCycles, 7'h26);
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], d);
            check(d, 13'h0000);
        end
        $display("test reset done");
    endtask

    task automatic t_fields();
        logic [12:0] d;
        logic [12:0] img [3:6] = '{13'h15AA, 13'h137C, 13'h0EA7, 13'h07F9};
        for (int a = 3; a < 7; a++) wr(a[2:0], img[a]);
        for (int a = 3; a < 6; a++) begin
            rd(a[2:0], d);
            check(d, img[a]);
        end
        rd(3'h6, d);
        check(d, 13'h0619);
        check({profileEntry3, profileEntry2, profileEntry8}, {5'h15, 5'h0A, 5'h19});
        check({profileEntry5, profileEntry4}, {5'h13, 5'h1C});
        check({profileEntry7, profileEntry6}, {5'h0E, 5'h07});
        check(stallThreshold, 8'hAE);
        check(pwmPinOe, 1'b0);
        check(pwmPeriodCycles, 11'h4E2);
        check(glitchFilterCycles, 7'h3F);
        $display("test fields done");
    endtask

    task automatic t_count();
        logic [12:0] d;
        logic [12:0] e;
        master.xfer({13'h1FFF, 3'h4}, 15, rx);
        master.xfer({13'h1FFF, 3'h4}, 17, rx);
        rd(3'h4, d);
        check(d, 13'h137C);
        check(profileEntry4, 5'h1C);
        rd(3'h4, e);
        check(e, d);
        $display("test count done");
    endtask

    task automatic t_status();
        logic [12:0] d;
        logic [7:0]  oc [2] = '{8'hA5, 8'h5A};
        logic [6:0]  lv [2] = '{7'h55, 7'h2A};
        logic [12:0] r7 [2] = '{13'h0AA5, 13'h055A};
        logic [12:0] r6 [2] = '{13'h06B9, 13'h0659};
        for (int k = 0; k < 2; k++) begin
            @(negedge core_clk);
            overcurrent = oc[k];
            lvls = lv[k];
            repeat (6) @(negedge core_clk);
            overcurrent = 8'h00;
            lvls = 7'h00;
            rd(3'h7, d);
            check(d, r7[k]);
            check(d[11:8], k ? 4'h5 : 4'hA);
            check(rx[2:1], 2'b11);
            check(bridgeDisable, lv[k][6]);
            rd(3'h6, d);
            check(d, r6[k]);
            wr(3'h7, 13'h1000);
            rd(3'h7, d);
            check(d, 13'h0000);
            check(rx[2:1], 2'b11);
            check(bridgeDisable, 1'b0);
            wr(3'h6, 13'h1619);
            rd(3'h6, d);
            check(d, 13'h0619);
            check(rx[2:1], 2'b00);
        end
        $display("test status done");
    endtask

    task automatic t_stall();
        logic [12:0] d;
        wr(3'h3, 13'h158A);
        check(pwmPinOe, 1'b1);
        quadrant();
        rd(3'h6, d);
        check(d, 13'h0719);
        check(rx[2:1], 2'b00);
        @(negedge core_clk);
        pwmBridgeA = 1'b1;
        // this quadrant ends with an empty sum and flags a stall, so clear after it
        quadrant();
        wr(3'h6, 13'h1619);
        repeat (2200) @(negedge core_clk);
        check(pwmPin, 1'b1);
        quadrant();
        pwmBridgeA = 1'b0;
        rd(3'h6, d);
        check(d, 13'h0619);
        wr(3'h6, 13'h0E19);
        @(negedge core_clk);
        pwmBridgeA = 1'b1;
        repeat (3) @(negedge core_clk);
        check(pwmPin, 1'b0);
        quadrant();
        check(pwmPin, 1'b1);
        $display("test stall done");
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        repeat (20) @(negedge core_clk);
        srst = 1'b0;
        repeat (5) @(negedge core_clk);
        t_reset();
        t_fields();
        t_count();
        t_status();
        t_stall();
        end_of_test();
    end
endmodule // sdr_reg_bank_test
